// >>> verilog/euc_map.vh
// Register map, field positions and timing counts of the execution unit
// control block. Assumes a 25 MHz core clock.
`ifndef EUC_MAP_VH
`define EUC_MAP_VH

// ----------------------------------------------------------------------
// Register indices (internal processor register numbers)
// ----------------------------------------------------------------------
`define EUC_ADDR_PATCH_STORE_CONTROL 8'h7c
`define EUC_ADDR_EXECUTION_UNIT_CONTROL 8'h7d

// ----------------------------------------------------------------------
// Patch store control fields
// ----------------------------------------------------------------------
`define EUC_PSC_REV_HI 28
`define EUC_PSC_REV_LO 24
`define EUC_PSC_NONSTD 23
`define EUC_PSC_DATA 12
`define EUC_PSC_SHIFT 11
`define EUC_PSC_COMMIT 10
`define EUC_PSC_OUT_ENB 9
`define EUC_PSC_PAR_DIS 8

// ----------------------------------------------------------------------
// Execution unit control fields
// ----------------------------------------------------------------------
`define EUC_ECR_MON_CLEAR 31
`define EUC_ECR_LFSR 22
`define EUC_ECR_EMUX_HI 21
`define EUC_ECR_EMUX_LO 19
`define EUC_ECR_PMUX_HI 18
`define EUC_ECR_PMUX_LO 17
`define EUC_ECR_MON_ENB 16
`define EUC_ECR_FTEST 13
`define EUC_ECR_TIMEOUT_CLOCK_BIT 6
`define EUC_ECR_TIMEOUT_SHORT_TEST 5
`define EUC_ECR_TO_OCC 4
`define EUC_ECR_ST4_BYP 3
`define EUC_ECR_TO_DIS 2
`define EUC_ECR_FENB 1

// ----------------------------------------------------------------------
// Reset values and geometry
// ----------------------------------------------------------------------
`define EUC_RESET_WORD 32'h00000000
`define EUC_CHAIN_LEN 64

// ----------------------------------------------------------------------
// Timing: printed times, clock rate, derived cycle counts
// ----------------------------------------------------------------------
`define EUC_CLK_HZ 25000000
`define EUC_TO_SHORT_US 50
`define EUC_TO_LONG_S 3
`define EUC_TO_SHORT_CYC ((`EUC_TO_SHORT_US * (`EUC_CLK_HZ / 1000000)))
`define EUC_TO_LONG_CYC ((`EUC_TO_LONG_S * `EUC_CLK_HZ))
`define EUC_TO_CNT_W 27

`endif

// >>> verilog/euc_patch_chain.v
// Serial patch read/write chain with a committed copy for RAM/CAM.
// Assumes strobes are one-cycle pulses on the core clock.
`default_nettype none
`include "euc_map.vh"

module euc_patch_chain
(
  input wire i_clk, // Core clock
  input wire i_rst_n, // Synchronised reset, active low
  input wire i_shift, // Shift one bit in
  input wire i_data, // Bit to insert
  input wire i_commit, // Copy chain to patch store
  output reg [`EUC_CHAIN_LEN-1:0] o_chain, // Chain contents
  output reg [`EUC_CHAIN_LEN-1:0] o_store // Committed RAM/CAM image
);

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_chain <= {`EUC_CHAIN_LEN{1'b0}};
      o_store <= {`EUC_CHAIN_LEN{1'b0}};
    end
    else
    begin
      if (i_shift)
        o_chain <= {o_chain[`EUC_CHAIN_LEN-2:0], i_data};
      if (i_commit)
        o_store <= o_chain;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/euc_stall_timer.v
// Stage-three stall timeout base counter.
// Assumes the stall input is synchronous to the core clock.
`default_nettype none
`include "euc_map.vh"

module euc_stall_timer
#(
  parameter [`EUC_TO_CNT_W-1:0] LONG_CYC = `EUC_TO_LONG_CYC,
  parameter [`EUC_TO_CNT_W-1:0] SHORT_CYC = `EUC_TO_SHORT_CYC
)
(
  input wire i_clk, // Core clock
  input wire i_rst_n, // Synchronised reset, active low
  input wire i_stall, // Stage-three stall level
  input wire i_short, // Short test period
  input wire i_disable, // Timeouts off
  output reg o_expire, // One-cycle expiry pulse
  output wire o_top_bit // Period's top bit of the count
);

  reg [`EUC_TO_CNT_W-1:0] count;
  wire [`EUC_TO_CNT_W-1:0] limit;

  assign limit = i_short ? SHORT_CYC : LONG_CYC;
  // Half-period marker: high for the upper half of each period
  assign o_top_bit = (count >= (limit >> 1));

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count <= {`EUC_TO_CNT_W{1'b0}};
      o_expire <= 1'b0;
    end
    else
    begin
      o_expire <= 1'b0;
      if (!i_stall || i_disable)
        count <= {`EUC_TO_CNT_W{1'b0}};
      else if (count >= limit - 1'b1)
      begin
        count <= {`EUC_TO_CNT_W{1'b0}};
        o_expire <= 1'b1;
      end
      else
        count <= count + 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/euc_ctrl_regs.v
// Execution unit patch store control and execution unit control registers.
// Assumes a one-cycle processor register access port on the core clock.
// Operation
// - Chain data bit is stored on each write; a shift takes the data bit of its own write.
// - Shift strobe inserts the data bit and advances the chain one place.
// - Commit strobe copies the whole chain into patch RAM and CAM.
// - Output enable makes patched microwords override the ROM.
// - Parallel-port disable removes the port's load and shift control.
// - Nonstandard flag shows a non-standard patch was loaded.
// - Monitor clear resets the counters, carried out by microcode.
// - Shift-accumulator bit enables the monitor test accumulator.
// - Event select picks the execution-unit event counted.
// - Source select picks the unit whose events are counted.
// - Monitor enable is the storage of the architectural enable.
// - Float test bit passes data through stages unchanged.
// - Timeout clock bit shows the top bit of the base counter.
// - Test bit gives about 50 us period, otherwise about 3 s.
// - Timeout flag sets on expiry and clears on a write of one.
// - Stage-4 bypass bit enables float stage-4 bypass.
// - Reserved bit set to one disables stall timeouts.
// - Float enable bit enables the floating-point unit.
`default_nettype none
`include "euc_map.vh"

module euc_ctrl_regs
#(
  parameter [`EUC_TO_CNT_W-1:0] LONG_CYC = `EUC_TO_LONG_CYC
)
(
  input wire i_sys_clk, // Core clock, 25 MHz
  input wire i_rst_n, // Asynchronous reset, active low
  input wire i_ipr_wr, // Register write strobe
  input wire i_ipr_rd, // Register read strobe
  input wire [7:0] i_ipr_addr, // Register number
  input wire [31:0] i_ipr_wdata, // Write data
  output reg [31:0] o_ipr_rdata, // Read data, valid cycle after read
  output reg o_ipr_rvalid, // Read data valid pulse
  input wire i_arch_mon_wr, // Architectural monitor enable write
  input wire i_arch_mon_wdata, // Value for that write
  output wire o_arch_monitor_enable, // Architectural enable view
  input wire i_par_shift, // Parallel port shift request
  input wire i_par_data, // Parallel port data bit
  input wire i_par_commit, // Parallel port commit request
  output wire [`EUC_CHAIN_LEN-1:0] o_patch_store, // Committed patch image
  output reg o_patch_output_enable, // Patches override ROM
  output reg [4:0] o_patch_revision, // Installed patch revision
  output reg o_nonstandard_patch, // Nonstandard patch loaded
  output reg o_monitor_clear, // Counter clear request pulse
  output wire o_monitor_shift_accum_enable, // Monitor test accumulator
  output wire [2:0] o_exec_event_select, // Execution-unit event
  output wire [1:0] o_event_source_select, // Event source unit
  output wire o_monitor_enable, // Performance monitor on
  output wire o_float_test_enable, // Float test pass-through
  output wire o_float_stage4_bypass_enable, // Float stage-4 bypass
  output wire o_float_unit_enable, // Float unit on
  input wire i_stage_three_stall, // Stage-three stall level
  output wire o_timeout_expire // Stall timeout pulse
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg rst_meta;
  reg rst_sync;
  wire rst_n;

  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  wire wr_psc;
  wire wr_ecr;
  wire rd_ecr;

  assign wr_psc = i_ipr_wr & hit(i_ipr_addr, `EUC_ADDR_PATCH_STORE_CONTROL);
  assign wr_ecr = i_ipr_wr &
    hit(i_ipr_addr, `EUC_ADDR_EXECUTION_UNIT_CONTROL);
  assign rd_ecr = i_ipr_rd &
    hit(i_ipr_addr, `EUC_ADDR_EXECUTION_UNIT_CONTROL);

  // --------------------------------------------------------------------
  // Patch store control
  // --------------------------------------------------------------------
  reg chain_data_bit;
  reg parallel_port_disable;
  wire reg_shift;
  wire reg_commit;
  wire chain_shift;
  wire chain_in;
  wire chain_commit;

  assign reg_shift = wr_psc & i_ipr_wdata[`EUC_PSC_SHIFT];
  assign reg_commit = wr_psc & i_ipr_wdata[`EUC_PSC_COMMIT];
  // Parallel port loses its say once disabled
  assign chain_shift = reg_shift |
    (i_par_shift & ~parallel_port_disable);
  assign chain_commit = reg_commit |
    (i_par_commit & ~parallel_port_disable);
  // Same-write data bit is used so one write can load and shift
  assign chain_in = reg_shift ?
    (wr_psc ? i_ipr_wdata[`EUC_PSC_DATA] : chain_data_bit) :
    i_par_data;

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chain_data_bit <= 1'b0;
      parallel_port_disable <= 1'b0;
      o_patch_output_enable <= 1'b0;
      o_patch_revision <= 5'h00;
      o_nonstandard_patch <= 1'b0;
    end
    else if (wr_psc)
    begin
      chain_data_bit <= i_ipr_wdata[`EUC_PSC_DATA];
      if (i_ipr_wdata[`EUC_PSC_OUT_ENB])
        o_patch_output_enable <= 1'b1;
      if (i_ipr_wdata[`EUC_PSC_PAR_DIS])
        parallel_port_disable <= 1'b1;
      o_patch_revision <=
        i_ipr_wdata[`EUC_PSC_REV_HI:`EUC_PSC_REV_LO];
      o_nonstandard_patch <= i_ipr_wdata[`EUC_PSC_NONSTD];
    end
  end

  euc_patch_chain u_chain
  (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_shift(chain_shift),
    .i_data(chain_in),
    .i_commit(chain_commit),
    .o_chain(),
    .o_store(o_patch_store)
  );

  // --------------------------------------------------------------------
  // Execution unit control
  // --------------------------------------------------------------------
  reg mon_lfsr;
  reg [2:0] emux;
  reg [1:0] pmux;
  reg mon_enb;
  reg ftest;
  reg timeout_short_test;
  reg to_occ;
  reg st4_byp;
  reg to_dis;
  reg fenb;
  wire expire;
  wire timeout_clock_bit;

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_lfsr <= 1'b0;
      emux <= 3'h0;
      pmux <= 2'h0;
      mon_enb <= 1'b0;
      ftest <= 1'b0;
      timeout_short_test <= 1'b0;
      st4_byp <= 1'b0;
      to_dis <= 1'b0;
      fenb <= 1'b0;
      o_monitor_clear <= 1'b0;
    end
    else
    begin
      o_monitor_clear <= wr_ecr & i_ipr_wdata[`EUC_ECR_MON_CLEAR];
      if (wr_ecr)
      begin
        mon_lfsr <= i_ipr_wdata[`EUC_ECR_LFSR];
        emux <= i_ipr_wdata[`EUC_ECR_EMUX_HI:`EUC_ECR_EMUX_LO];
        pmux <= i_ipr_wdata[`EUC_ECR_PMUX_HI:`EUC_ECR_PMUX_LO];
        mon_enb <= i_ipr_wdata[`EUC_ECR_MON_ENB];
        ftest <= i_ipr_wdata[`EUC_ECR_FTEST];
        timeout_short_test <= i_ipr_wdata[`EUC_ECR_TIMEOUT_SHORT_TEST];
        st4_byp <= i_ipr_wdata[`EUC_ECR_ST4_BYP];
        to_dis <= i_ipr_wdata[`EUC_ECR_TO_DIS];
        fenb <= i_ipr_wdata[`EUC_ECR_FENB];
      end
      else if (i_arch_mon_wr)
        mon_enb <= i_arch_mon_wdata;
    end
  end

  // Expiry wins over a same-cycle clear so no timeout is lost
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      to_occ <= 1'b0;
    else if (expire)
      to_occ <= 1'b1;
    else if (wr_ecr & i_ipr_wdata[`EUC_ECR_TO_OCC])
      to_occ <= 1'b0;
  end

  euc_stall_timer #(.LONG_CYC(LONG_CYC)) u_timer
  (
    .i_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_stall(i_stage_three_stall),
    .i_short(timeout_short_test),
    .i_disable(to_dis),
    .o_expire(expire),
    .o_top_bit(timeout_clock_bit)
  );

  assign o_timeout_expire = expire;
  assign o_arch_monitor_enable = mon_enb;
  assign o_monitor_enable = mon_enb;
  assign o_monitor_shift_accum_enable = mon_lfsr;
  assign o_exec_event_select = emux;
  assign o_event_source_select = pmux;
  assign o_float_test_enable = ftest;
  assign o_float_stage4_bypass_enable = st4_byp;
  assign o_float_unit_enable = fenb;

  // --------------------------------------------------------------------
  // Read port; patch store control is write-only and reads zero
  // --------------------------------------------------------------------
  reg [31:0] next_rdata;

  always @*
  begin
    next_rdata = 32'h00000000;
    if (rd_ecr)
    begin
      next_rdata[`EUC_ECR_LFSR] = mon_lfsr;
      next_rdata[`EUC_ECR_EMUX_HI:`EUC_ECR_EMUX_LO] = emux;
      next_rdata[`EUC_ECR_PMUX_HI:`EUC_ECR_PMUX_LO] = pmux;
      next_rdata[`EUC_ECR_MON_ENB] = mon_enb;
      next_rdata[`EUC_ECR_FTEST] = ftest;
      next_rdata[`EUC_ECR_TIMEOUT_CLOCK_BIT] = timeout_clock_bit;
      next_rdata[`EUC_ECR_TIMEOUT_SHORT_TEST] = timeout_short_test;
      next_rdata[`EUC_ECR_TO_OCC] = to_occ;
      next_rdata[`EUC_ECR_ST4_BYP] = st4_byp;
      next_rdata[`EUC_ECR_TO_DIS] = to_dis;
      next_rdata[`EUC_ECR_FENB] = fenb;
    end
  end

  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_ipr_rdata <= 32'h00000000;
      o_ipr_rvalid <= 1'b0;
    end
    else
    begin
      o_ipr_rdata <= next_rdata;
      o_ipr_rvalid <= i_ipr_rd;
    end
  end

endmodule
`default_nettype wire

// >>> dv/euc_ctrl_regs_properties.sv
// Port checks for the execution unit control register block.
// Assumes binding onto euc_ctrl_regs; one core clock domain.
`default_nettype none
`include "euc_map.vh"

module euc_ctrl_regs_properties
#(
  parameter [`EUC_TO_CNT_W-1:0] LONG_CYC = `EUC_TO_LONG_CYC
)
(
  input wire logic i_sys_clk, // Core clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_ipr_wr, // Write strobe
  input wire logic [7:0] i_ipr_addr, // Register number
  input wire logic [31:0] i_ipr_wdata, // Write data
  input wire logic o_patch_output_enable, // Patch override
  input wire logic o_nonstandard_patch, // Nonstandard flag
  input wire logic o_monitor_clear, // Clear pulse
  input wire logic [2:0] o_exec_event_select, // Event select
  input wire logic o_monitor_enable, // Monitor on
  input wire logic o_arch_monitor_enable, // Arch view
  input wire logic o_float_unit_enable, // Float on
  input wire logic i_stage_three_stall, // Stall level
  input wire logic o_timeout_expire // Timeout pulse
);
  wire logic wr_pc;
  wire logic wr_eu;
  assign wr_pc = i_ipr_wr && i_ipr_addr == 8'h7c;
  assign wr_eu = i_ipr_wr && i_ipr_addr == 8'h7d;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_patch_enable_set: assert property (
    wr_pc && i_ipr_wdata[9] |=> o_patch_output_enable[*3])
    else $error("patch enable not set");
  chk_nonstd_load: assert property (
    wr_pc |=> o_nonstandard_patch == $past(i_ipr_wdata[23]))
    else $error("nonstandard flag wrong");
  chk_clear_pulse: assert property (
    wr_eu && i_ipr_wdata[31] |=> o_monitor_clear ##1 !o_monitor_clear)
    else $error("monitor clear pulse wrong");
  chk_event_select: assert property (
    wr_eu |=> o_exec_event_select == $past(i_ipr_wdata[21:19]))
    else $error("event select wrong");
  chk_monitor_views: assert property (
    o_monitor_enable == o_arch_monitor_enable)
    else $error("monitor views differ");
  chk_float_enable: assert property (
    wr_eu |=> o_float_unit_enable == $past(i_ipr_wdata[1]))
    else $error("float enable wrong");
  chk_expire_single: assert property (
    o_timeout_expire |=> !o_timeout_expire)
    else $error("expire pulse too long");
  chk_stall_restart: assert property (
    !i_stage_three_stall ##1 !i_stage_three_stall |=> !o_timeout_expire)
    else $error("expire without stall");
  chk_timeout_off: assert property (
    wr_eu && i_ipr_wdata[2] |=> ##1 !o_timeout_expire[*3])
    else $error("expire while disabled");
endmodule

bind euc_ctrl_regs euc_ctrl_regs_properties #(.LONG_CYC(LONG_CYC)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ipr_wr(i_ipr_wr),
  .i_ipr_addr(i_ipr_addr), .i_ipr_wdata(i_ipr_wdata),
  .o_patch_output_enable(o_patch_output_enable),
  .o_nonstandard_patch(o_nonstandard_patch),
  .o_monitor_clear(o_monitor_clear),
  .o_exec_event_select(o_exec_event_select),
  .o_monitor_enable(o_monitor_enable),
  .o_arch_monitor_enable(o_arch_monitor_enable),
  .o_float_unit_enable(o_float_unit_enable),
  .i_stage_three_stall(i_stage_three_stall),
  .o_timeout_expire(o_timeout_expire));
`default_nettype wire

// >>> dv/euc_ctrl_regs_tb_top.sv
// Self-checking bench for the execution unit control registers.
// Assumes euc_ctrl_regs alone, with a shortened long timeout period.
`default_nettype none

module euc_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [26:0] LONG = 27'd2000;
  localparam [7:0] A_PC = 8'h7c;
  localparam [7:0] A_EU = 8'h7d;
  // Palindromes, so shift direction does not matter
  localparam [63:0] PAT_A = 64'hc3a512481248a5c3;
  localparam [63:0] PAT_B = 64'hffff00000000ffff;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, amw = 0, amd = 0;
  logic ps = 0, pd = 0, pc = 0, stall = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  wire [31:0] o_rd;
  wire rv, ope, nsp, mcl, msa, men, ame, fte, byp, fen, expire;
  wire [2:0] ev;
  wire [1:0] src;
  wire [4:0] rev;
  wire [63:0] store;
  int error_cnt = 0, num_checks = 0, n_exp = 0;

  euc_ctrl_regs #(.LONG_CYC(LONG)) u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_ipr_wr(wr), .i_ipr_rd(rd),
    .i_ipr_addr(addr), .i_ipr_wdata(wd), .o_ipr_rdata(o_rd),
    .o_ipr_rvalid(rv), .i_arch_mon_wr(amw), .i_arch_mon_wdata(amd),
    .o_arch_monitor_enable(ame), .i_par_shift(ps), .i_par_data(pd),
    .i_par_commit(pc), .o_patch_store(store),
    .o_patch_output_enable(ope), .o_patch_revision(rev),
    .o_nonstandard_patch(nsp), .o_monitor_clear(mcl),
    .o_monitor_shift_accum_enable(msa), .o_exec_event_select(ev),
    .o_event_source_select(src), .o_monitor_enable(men),
    .o_float_test_enable(fte), .o_float_stage4_bypass_enable(byp),
    .o_float_unit_enable(fen), .i_stage_three_stall(stall),
    .o_timeout_expire(expire));

  always #20 clk = ~clk;
  always @(posedge clk) if (expire === 1'b1) n_exp <= n_exp + 1;
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] want);
    num_checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // Ends at a falling edge so outputs have settled
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(64'(rv), 64'h1);
    d = o_rd;
  endtask
  task automatic par_load(input logic [63:0] p, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      ps <= 1'b1;
      pd <= p[i];
      @(posedge clk);
      ps <= 1'b0;
    end
    pc <= 1'b1;
    @(posedge clk);
    pc <= 1'b0;
    @(negedge clk);
  endtask
  task automatic stl(input int n, input int want);
    int base;
    base = n_exp;
    @(posedge clk);
    stall <= 1'b1;
    repeat (n) @(posedge clk);
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    cmp(64'(n_exp - base), 64'(want));
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(A_EU, rdat);
    cmp(rdat, 0);
    rdr(8'h55, rdat);
    cmp(rdat, 0);
    wrr(A_EU, 32'h007f200a);
    rdr(A_EU, rdat);
    cmp(rdat, 32'h007f200a);
    cmp({msa, ev, src, men, fte, byp, fen}, 10'h3ff);
    for (int i = 0; i < 8; i++)
    begin
      wrr(A_EU, (32'(i) << 19) | (32'(i % 4) << 17));
      cmp({ev, src, msa, fen}, {3'(i), 2'(i % 4), 2'b00});
    end
    wrr(A_EU, 32'h80010000);
    cmp({mcl, men}, 2'b11);
    @(negedge clk);
    cmp(mcl, 0);
    @(posedge clk);
    amw <= 1'b1;
    @(posedge clk);
    amw <= 1'b0;
    rdr(A_EU, rdat);
    cmp({rdat[16], men, ame}, 3'b000);
    par_load(PAT_B, 64);
    cmp(store, PAT_B);
    for (int i = 0; i < 64; i++)
      wrr(A_PC, (32'(PAT_A[i]) << 12) | 32'h800);
    cmp(store, PAT_B);
    wrr(A_PC, 32'h1000);
    wrr(A_PC, 32'h400);
    cmp(store, PAT_A);
    wrr(A_PC, 32'h100);
    par_load(64'h0, 8);
    cmp(store, PAT_A);
    wrr(A_PC, 32'h15800200);
    cmp({ope, rev, nsp}, 7'h6b);
    wrr(A_PC, 32'h0);
    cmp({ope, rev, nsp}, 7'h40);
    rdr(A_PC, rdat);
    cmp(rdat, 0);
    wrr(A_EU, 32'h20);
    @(posedge clk);
    stall <= 1'b1;
    repeat (300) @(posedge clk);
    rdr(A_EU, rdat);
    cmp(rdat[6], 0);
    repeat (500) @(posedge clk);
    rdr(A_EU, rdat);
    cmp(rdat[6], 1);
    @(posedge clk);
    stall <= 1'b0;
    stl(1240, 0);
    stl(1260, 1);
    wrr(A_EU, 32'h20);
    rdr(A_EU, rdat);
    cmp(rdat[5:4], 2'b11);
    wrr(A_EU, 32'h30);
    rdr(A_EU, rdat);
    cmp(rdat[5:4], 2'b10);
    @(posedge clk);
    stall <= 1'b1;
    repeat (1000) @(posedge clk);
    stall <= 1'b0;
    stl(1000, 0);
    wrr(A_EU, 32'h24);
    stl(1300, 0);
    wrr(A_EU, 32'h0);
    stl(1300, 0);
    stl(2010, 1);
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
